// file: mpalu_defines.vh
`ifndef MPALU_DEFINES_VH
`define MPALU_DEFINES_VH

// apb byte offsets
`define MPALU_OFF_INSTR 8'h00
`define MPALU_OFF_STATUS 8'h04
`define MPALU_OFF_DREG 8'h08
`define MPALU_OFF_AREG 8'h0c
`define MPALU_OFF_LSRADDR 8'h10
`define MPALU_OFF_LSRDATA 8'h14
`define MPALU_OFF_HWERR 8'h18
`define MPALU_OFF_DEVIN 8'h1c
`define MPALU_OFF_TAGREQ 8'h20
`define MPALU_OFF_COUNTER 8'h24

// instruction command word fields
`define MPALU_CMD_HILO 16
`define MPALU_CMD_PARHI 17
`define MPALU_CMD_PARLO 18

// status fields
`define MPALU_ST_BUSY 0
`define MPALU_ST_CARRY 1
`define MPALU_ST_ZERO 2
`define MPALU_ST_PARERR 3

// operation codes, upper nibble of the instruction
`define MPALU_OP_OR_STORE 4'h8
`define MPALU_OP_OR_CMP 4'h9
`define MPALU_OP_ADD_STORE 4'ha
`define MPALU_OP_ADD_CMP 4'hb
`define MPALU_OP_AND_STORE 4'hc
`define MPALU_OP_AND_CMP 4'hd
`define MPALU_OP_XFR 4'h6

// phases of one long microcycle
`define MPALU_PH_FETCH 3'h0
`define MPALU_PH_LOOK 3'h1
`define MPALU_PH_ALU 3'h2
`define MPALU_PH_DEGATE 3'h3
`define MPALU_PH_DLOAD 3'h4
`define MPALU_PH_BUSIN 3'h5
`define MPALU_PH_LSRWR 3'h6
`define MPALU_PH_ARESET 3'h7

// reset values
`define MPALU_RST_BYTE 8'h00
`define MPALU_RST_IC 11'h000

`endif

// file: mpalu_oddpar.v
`timescale 1ns/100ps
`default_nettype none

module mpalu_oddpar #(
    parameter W = 8
) (
    input wire [W-1:0] data,
    output wire parity
);

    // the W data bits and the parity bit together always odd
    assign parity = ~(^data);

endmodule // mpalu_oddpar

`default_nettype wire

// file: mpalu_lsr.v
`timescale 1ns/100ps
`default_nettype none

module mpalu_lsr #(
    parameter AW = 5,
    parameter DW = 8
) (
    input wire clk,
    input wire writeEn,
    input wire [AW-1:0] writeAddr,
    input wire [DW-1:0] writeData,
    input wire [AW-1:0] readAddrA,
    output wire [DW-1:0] readDataA,
    input wire [AW-1:0] readAddrB,
    output wire [DW-1:0] readDataB
);

    // storage content is not reset, as in the real register file
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk)
    begin
        if (writeEn)
        begin
            mem[writeAddr] <= writeData;
        end
    end

    assign readDataA = mem[readAddrA];
    assign readDataB = mem[readAddrB];

endmodule // mpalu_lsr

`default_nettype wire

// file: mpalu_top.v
// Local design decisions: the APB register port and the address map.
`include "mpalu_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module mpalu_top #(
    parameter TWO_CHANNEL = 1
) (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [7:0] channelBusOut,
    input wire [7:0] hwErrIn,
    input wire [7:0] devBusIn,
    input wire reqSupA,
    input wire reqNonSupA,
    input wire reqSupB,
    input wire reqNonSupB,
    output wire [7:0] resultBus,
    output wire carryOut,
    output wire resultZero,
    output wire cycleBusy,
    output wire [7:0] hwErrBits,
    output wire hwErrParity,
    output wire [7:0] devBitsLatched,
    output wire devBitsParity,
    output wire [7:0] tagRequestIn
);

    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;

    function isAluOp;
        input [3:0] op;
        begin
            isAluOp = (op == `MPALU_OP_OR_STORE) ||
                      (op == `MPALU_OP_OR_CMP) ||
                      (op == `MPALU_OP_ADD_STORE) ||
                      (op == `MPALU_OP_ADD_CMP) ||
                      (op == `MPALU_OP_AND_STORE) ||
                      (op == `MPALU_OP_AND_CMP);
        end
    endfunction

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [2:0] phase_q;
    reg [18:0] cmd_q;
    reg [15:0] instr_q;
    reg hiLo_q;
    reg [10:0] ic_q;
    reg [10:0] lookahead_q;
    reg [7:0] aReg_q;
    reg [7:0] aluOut_q;
    reg aluCarry_q;
    reg degate_q;
    reg [7:0] dReg_q;
    reg carry_q;
    reg parErr_q;
    reg [7:0] devBits_q;
    reg [7:0] tagReg_q;
    reg [4:0] lsrAddr_q;

    wire [3:0] opCode;
    wire bit3;
    wire [3:0] field1;
    wire [7:0] constField;
    wire [4:0] lsrSel;
    wire [7:0] aBus;
    wire [7:0] bBus;
    wire [7:0] apbLsrData;
    wire [8:0] sum;
    wire aluOp;
    wire xfrOp;
    wire running;
    // a generator output high flags a nine-bit group with even parity
    wire parHiBad;
    wire parLoBad;
    wire seqLsrWe;
    wire apbLsrWe;
    wire lsrWe;
    wire [7:0] lsrWData;
    wire [4:0] lsrWAddr;
    wire apbSetup;
    wire apbAccess;
    wire apbWrite;
    wire decodeHit;
    wire busyRefuse;
    reg [7:0] aluNext;
    reg [7:0] dIn;
    reg [31:0] readMux;

    assign opCode = instr_q[15:12];
    assign bit3 = instr_q[12];
    assign field1 = instr_q[11:8];
    assign constField = instr_q[7:0];
    assign lsrSel = {hiLo_q, field1};
    assign aluOp = isAluOp(opCode);
    assign xfrOp = (opCode == `MPALU_OP_XFR);
    assign running = (state_q == ST_RUN);

    assign aBus = aReg_q | constField;

    // B bus always sees the addressed byte; apb port reads the other side
    mpalu_lsr #(
        .AW(5),
        .DW(8)
    ) uLsr (
        .clk(clk),
        .writeEn(lsrWe),
        .writeAddr(lsrWAddr),
        .writeData(lsrWData),
        .readAddrA(lsrSel),
        .readDataA(bBus),
        .readAddrB(lsrAddr_q),
        .readDataB(apbLsrData)
    );

    assign sum = {1'b0, aBus} + {1'b0, bBus};

    always @*
    begin
        aluNext = 8'h00;
        case (opCode)
            `MPALU_OP_ADD_STORE, `MPALU_OP_ADD_CMP:
                aluNext = sum[7:0];
            `MPALU_OP_AND_STORE, `MPALU_OP_AND_CMP:
                aluNext = aBus & bBus;
            `MPALU_OP_OR_STORE, `MPALU_OP_OR_CMP:
                aluNext = aBus | bBus;
            default:
                aluNext = 8'h00;
        endcase
    end

    // sources are wired-or; a source that is off adds zeros, so unused
    // positions end up cleared on the load pulse
    always @*
    begin
        dIn = 8'h00;
        if (!degate_q)
        begin
            dIn = dIn | aluOut_q;
        end
        if (xfrOp)
        begin
            dIn = dIn | channelBusOut;
        end
    end

    // bit 3 set blocks the write gate for every compare-only variant
    assign seqLsrWe = running && (phase_q == `MPALU_PH_LSRWR) &&
                      (aluOp || xfrOp) && !bit3;

    mpalu_oddpar #(
        .W(9)
    ) uParHi (
        .data({cmd_q[15:8], cmd_q[`MPALU_CMD_PARHI]}),
        .parity(parHiBad)
    );

    mpalu_oddpar #(
        .W(9)
    ) uParLo (
        .data({cmd_q[7:0], cmd_q[`MPALU_CMD_PARLO]}),
        .parity(parLoBad)
    );

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (apbWrite && paddr == `MPALU_OFF_INSTR)
                begin
                    state_d = ST_RUN;
                end
            ST_RUN:
                if (phase_q == `MPALU_PH_ARESET)
                begin
                    state_d = ST_IDLE;
                end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            phase_q <= `MPALU_PH_FETCH;
            cmd_q <= 19'h00000;
            instr_q <= 16'h0000;
            hiLo_q <= 1'b0;
            ic_q <= `MPALU_RST_IC;
            lookahead_q <= `MPALU_RST_IC;
            aluOut_q <= `MPALU_RST_BYTE;
            aluCarry_q <= 1'b0;
            degate_q <= 1'b0;
            dReg_q <= `MPALU_RST_BYTE;
            carry_q <= 1'b0;
            devBits_q <= `MPALU_RST_BYTE;
        end
        else
        begin
            state_q <= state_d;
            if (!running && apbWrite && paddr == `MPALU_OFF_INSTR)
            begin
                cmd_q <= pwdata[18:0];
                phase_q <= `MPALU_PH_FETCH;
            end
            if (apbWrite && !running && paddr == `MPALU_OFF_COUNTER)
            begin
                ic_q <= pwdata[10:0];
            end
            if (running)
            begin
                phase_q <= phase_q + 3'h1;
                case (phase_q)
                    `MPALU_PH_FETCH:
                    begin
                        ic_q <= ic_q + 11'h001;
                        instr_q <= cmd_q[15:0];
                        hiLo_q <= cmd_q[`MPALU_CMD_HILO];
                        degate_q <= 1'b0;
                    end
                    `MPALU_PH_LOOK:
                        lookahead_q <= ic_q + 11'h001;
                    `MPALU_PH_ALU:
                    begin
                        aluOut_q <= aluNext;
                        aluCarry_q <= sum[8];
                    end
                    `MPALU_PH_DEGATE:
                        if (xfrOp)
                        begin
                            degate_q <= 1'b1;
                        end
                    `MPALU_PH_DLOAD:
                        // only alu and transfer touch the result register
                        if (aluOp || xfrOp)
                        begin
                            dReg_q <= dIn;
                            if (opCode == `MPALU_OP_ADD_STORE ||
                                opCode == `MPALU_OP_ADD_CMP)
                            begin
                                carry_q <= aluCarry_q;
                            end
                        end
                    `MPALU_PH_BUSIN:
                        devBits_q <= devBusIn;
                    default:
                        phase_q <= phase_q + 3'h1;
                endcase
            end
        end
    end

    // parity flag: the check at fetch beats a same-cycle software clear
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            parErr_q <= 1'b0;
        end
        else if (running && phase_q == `MPALU_PH_FETCH &&
                 (parHiBad || parLoBad))
        begin
            parErr_q <= 1'b1;
        end
        else if (apbWrite && paddr == `MPALU_OFF_STATUS &&
                 pwdata[`MPALU_ST_PARERR])
        begin
            parErr_q <= 1'b0;
        end
    end

    // software loads A only while idle, so the phase 7 clear never races
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            aReg_q <= `MPALU_RST_BYTE;
        end
        else if (running && phase_q == `MPALU_PH_ARESET && aluOp)
        begin
            aReg_q <= `MPALU_RST_BYTE;
        end
        else if (apbWrite && !running && paddr == `MPALU_OFF_AREG)
        begin
            aReg_q <= pwdata[7:0];
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            tagReg_q <= `MPALU_RST_BYTE;
            lsrAddr_q <= 5'h00;
        end
        else
        begin
            if (TWO_CHANNEL != 0)
            begin
                tagReg_q <= {4'h0, reqSupA, reqNonSupA,
                             reqSupB, reqNonSupB};
            end
            else
            begin
                tagReg_q <= `MPALU_RST_BYTE;
            end
            if (apbWrite && paddr == `MPALU_OFF_LSRADDR)
            begin
                lsrAddr_q <= pwdata[4:0];
            end
        end
    end

    assign apbSetup = psel && !penable;
    assign apbAccess = psel && penable;
    assign decodeHit = (paddr == `MPALU_OFF_INSTR) ||
                       (paddr == `MPALU_OFF_STATUS) ||
                       (paddr == `MPALU_OFF_DREG) ||
                       (paddr == `MPALU_OFF_AREG) ||
                       (paddr == `MPALU_OFF_LSRADDR) ||
                       (paddr == `MPALU_OFF_LSRDATA) ||
                       (paddr == `MPALU_OFF_HWERR) ||
                       (paddr == `MPALU_OFF_DEVIN) ||
                       (paddr == `MPALU_OFF_TAGREQ) ||
                       (paddr == `MPALU_OFF_COUNTER);
    // writes that would race the sequencer are refused while busy
    assign busyRefuse = running && pwrite &&
                        ((paddr == `MPALU_OFF_INSTR) ||
                         (paddr == `MPALU_OFF_AREG) ||
                         (paddr == `MPALU_OFF_LSRDATA) ||
                         (paddr == `MPALU_OFF_COUNTER));
    assign pready = 1'b1;
    assign pslverr = apbAccess && (!decodeHit || busyRefuse);
    assign apbWrite = apbAccess && pwrite && decodeHit;
    assign apbLsrWe = apbWrite && !running &&
                      (paddr == `MPALU_OFF_LSRDATA);
    assign lsrWe = seqLsrWe || apbLsrWe;
    assign lsrWAddr = seqLsrWe ? lsrSel : lsrAddr_q;
    assign lsrWData = seqLsrWe ? dReg_q : pwdata[7:0];

    always @*
    begin
        readMux = 32'h00000000;
        case (paddr)
            `MPALU_OFF_INSTR:
                readMux = {16'h0000, instr_q};
            `MPALU_OFF_STATUS:
                readMux = {28'h0000000, parErr_q, resultZero,
                           carry_q, running};
            `MPALU_OFF_DREG:
                readMux = {24'h000000, dReg_q};
            `MPALU_OFF_AREG:
                readMux = {24'h000000, aReg_q};
            `MPALU_OFF_LSRADDR:
                readMux = {27'h0000000, lsrAddr_q};
            `MPALU_OFF_LSRDATA:
                readMux = {24'h000000, apbLsrData};
            `MPALU_OFF_HWERR:
                readMux = {23'h000000, hwErrParity, hwErrBits};
            `MPALU_OFF_DEVIN:
                readMux = {23'h000000, devBitsParity, devBits_q};
            `MPALU_OFF_TAGREQ:
                readMux = {24'h000000, tagReg_q};
            `MPALU_OFF_COUNTER:
                readMux = {5'h00, lookahead_q, 5'h00, ic_q};
            default:
                readMux = 32'h00000000;
        endcase
    end

    // read data is captured in setup so it comes from a flop in access
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h00000000;
        end
        else if (apbSetup && !pwrite)
        begin
            prdata <= readMux;
        end
    end

    // error path is transparent by design: no gate, no latchback
    assign hwErrBits = hwErrIn;

    mpalu_oddpar #(
        .W(8)
    ) uParErr (
        .data(hwErrIn),
        .parity(hwErrParity)
    );

    mpalu_oddpar #(
        .W(8)
    ) uParDev (
        .data(devBits_q),
        .parity(devBitsParity)
    );

    assign resultBus = dReg_q;
    assign carryOut = carry_q;
    assign resultZero = (dReg_q == 8'h00);
    assign cycleBusy = running;
    assign devBitsLatched = devBits_q;
    assign tagRequestIn = tagReg_q;

endmodule // mpalu_top

`default_nettype wire

// file: mpalu_far_model.sv
`timescale 1ns/100ps
`default_nettype none
// one byte from the bench is spread into distinct patterns per line group,
// so a swapped or stuck source shows up as a mismatch
module mpalu_far_model (
    input wire logic [7:0] pattern,
    output logic [7:0] channelBusOut,
    output logic [7:0] hwErrIn,
    output logic [7:0] devBusIn,
    output logic reqSupA,
    output logic reqNonSupA,
    output logic reqSupB,
    output logic reqNonSupB
);
    assign channelBusOut = pattern;
    assign hwErrIn = ~pattern;
    assign devBusIn = pattern ^ 8'h5a;
    assign {reqSupA, reqNonSupA, reqSupB, reqNonSupB} = pattern[3:0];
endmodule // mpalu_far_model
`default_nettype wire

// file: mpalu_checker_sva.sv
`timescale 1ns/100ps
`default_nettype none
module mpalu_checker #(
    parameter TWO_CHANNEL = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic [7:0] hwErrIn,
    input wire logic [7:0] devBusIn,
    input wire logic reqSupA,
    input wire logic reqNonSupA,
    input wire logic reqSupB,
    input wire logic reqNonSupB,
    input wire logic [7:0] resultBus,
    input wire logic resultZero,
    input wire logic cycleBusy,
    input wire logic [7:0] hwErrBits,
    input wire logic hwErrParity,
    input wire logic [7:0] devBitsLatched,
    input wire logic devBitsParity,
    input wire logic [7:0] tagRequestIn
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_cycleStart;
        $rose(cycleBusy);
    endsequence
    sequence s_cycleBody;
        cycleBusy [*8] ##1 !cycleBusy;
    endsequence
    property p_busyLen;
        s_cycleStart |-> s_cycleBody;
    endproperty
    a_busyLen: assert property (p_busyLen)
        else $error("microcycle length wrong");
    property p_devLatch;
        s_cycleStart |-> ##6 devBitsLatched == $past(devBusIn);
    endproperty
    a_devLatch: assert property (p_devLatch)
        else $error("device bits not latched on bus-in pulse");
    property p_hwPass;
        hwErrBits == hwErrIn;
    endproperty
    a_hwPass: assert property (p_hwPass)
        else $error("error lines not passed through");
    property p_hwPar;
        ^{hwErrParity, hwErrBits};
    endproperty
    a_hwPar: assert property (p_hwPar)
        else $error("error byte parity not odd");
    property p_devPar;
        ^{devBitsParity, devBitsLatched};
    endproperty
    a_devPar: assert property (p_devPar)
        else $error("device byte parity not odd");
    property p_tag;
        $past(rst_n) |-> tagRequestIn == (TWO_CHANNEL ? {4'h0,
            $past(reqSupA), $past(reqNonSupA), $past(reqSupB),
            $past(reqNonSupB)} : 8'h00);
    endproperty
    a_tag: assert property (p_tag)
        else $error("request-in bits wrong");
    property p_zero;
        resultZero == (resultBus == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag disagrees with result");
    property p_hold;
        $past(rst_n) && !cycleBusy |-> $stable(resultBus);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed outside a microcycle");
    property p_refuse;
        psel && penable && pwrite && cycleBusy && paddr == 8'h00
            |-> pslverr;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("instruction write while busy not refused");
endmodule // mpalu_checker
bind mpalu_top mpalu_checker #(.TWO_CHANNEL(TWO_CHANNEL)) mpalu_checker_i (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pslverr, .hwErrIn,
    .devBusIn, .reqSupA, .reqNonSupA, .reqSupB, .reqNonSupB, .resultBus,
    .resultZero, .cycleBusy, .hwErrBits, .hwErrParity, .devBitsLatched,
    .devBitsParity, .tagRequestIn);
`default_nettype wire

// file: mpalu_tb_top.sv
`include "mpalu_defines.vh"
`timescale 1ns/100ps
`default_nettype none
`define MPALU_TB_CHK(got, exp) \
    begin \
        nCompared = nCompared + 1; \
        if ((got) !== (exp)) \
        begin \
            nFail = nFail + 1; \
            $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
        end \
    end
module mpalu_tb_top;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 0, pattern = 0, lsrVal, res;
    logic [31:0] pwdata = 0, rd, prdata;
    logic pready, pslverr, carryOut, resultZero, cycleBusy;
    logic hwErrParity, devBitsParity, rqSA, rqNA, rqSB, rqNB;
    logic [7:0] chOut, hwIn, devIn, resultBus, hwErrBits, devBitsLatched;
    logic [7:0] tagRequestIn;
    logic [8:0] sum;
    logic [10:0] icExp;
    logic [3:0] ops [6] = '{4'ha, 4'hb, 4'hc, 4'hd, 4'h8, 4'h9};
    int nFail = 0, nCompared = 0, cycles = 0;
    mpalu_top mpalu_top_i (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .channelBusOut(chOut), .hwErrIn(hwIn), .devBusIn(devIn),
        .reqSupA(rqSA), .reqNonSupA(rqNA), .reqSupB(rqSB), .reqNonSupB(rqNB),
        .resultBus(resultBus), .carryOut(carryOut), .resultZero(resultZero),
        .cycleBusy(cycleBusy), .hwErrBits(hwErrBits),
        .hwErrParity(hwErrParity), .devBitsLatched(devBitsLatched),
        .devBitsParity(devBitsParity), .tagRequestIn(tagRequestIn));
    mpalu_far_model mpalu_far_model_i (.pattern(pattern),
        .channelBusOut(chOut), .hwErrIn(hwIn), .devBusIn(devIn),
        .reqSupA(rqSA), .reqNonSupA(rqNA), .reqSupB(rqSB), .reqNonSupB(rqNB));
    always #4 clk = ~clk;
    task finalReport();
        $display("compared %0d failed %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            nFail = nFail + 1;
            finalReport();
        end
    end
    // idle edge at the end so back-to-back calls never retouch psel
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task runInstr(input logic [3:0] op, input logic [7:0] k, input logic bad);
        logic [15:0] ins;
        ins = {op, 4'h3, k};
        apb(1, `MPALU_OFF_INSTR, {13'h0, ~^ins[7:0], ~^ins[15:8] ^ bad,
            1'b0, ins});
        apb(1, `MPALU_OFF_INSTR, 32'h0);
        `MPALU_TB_CHK(err, 1'b1)
        while (cycleBusy !== 1'b0) @(posedge clk);
        icExp = icExp + 11'h001;
    endtask
    initial
    begin
        icExp = 11'h000;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(0, `MPALU_OFF_DREG, 32'h0);
        `MPALU_TB_CHK(rd, 32'h0)
        apb(0, 8'h28, 32'h0);
        `MPALU_TB_CHK({err, rd}, {1'b1, 32'h0})
        apb(1, `MPALU_OFF_LSRADDR, 32'h3);
        foreach (ops[i])
        begin
            apb(1, `MPALU_OFF_LSRDATA, 32'he7);
            apb(1, `MPALU_OFF_AREG, 32'h50);
            runInstr(ops[i], 8'h81, 1'b0);
            // A bus d1 makes the OR result differ from the stored byte
            sum = 9'h0d1 + 9'h0e7;
            res = ops[i][2] ? 8'hd1 & 8'he7 :
                  ops[i][1] ? sum[7:0] : 8'hd1 | 8'he7;
            lsrVal = ops[i][0] ? 8'he7 : res;
            `MPALU_TB_CHK(resultBus, res)
            apb(0, `MPALU_OFF_LSRDATA, 32'h0);
            `MPALU_TB_CHK(rd[7:0], lsrVal)
            apb(0, `MPALU_OFF_AREG, 32'h0);
            `MPALU_TB_CHK(rd, 32'h0)
            if (ops[i][3:1] == 3'b101)
                `MPALU_TB_CHK(carryOut, sum[8])
        end
        // transfer takes the outbound bus and leaves the A register alone
        apb(1, `MPALU_OFF_AREG, 32'h55);
        pattern <= 8'h3c;
        runInstr(`MPALU_OP_XFR, 8'h00, 1'b0);
        `MPALU_TB_CHK({resultZero, resultBus}, 9'h03c)
        apb(0, `MPALU_OFF_AREG, 32'h0);
        `MPALU_TB_CHK(rd, 32'h55)
        apb(0, `MPALU_OFF_LSRDATA, 32'h0);
        `MPALU_TB_CHK(rd, 32'h3c)
        // good parity so far keeps the flag clear; carry stays from last add
        apb(0, `MPALU_OFF_STATUS, 32'h0);
        `MPALU_TB_CHK(rd, 32'h2)
        pattern <= 8'h96;
        runInstr(4'h0, 8'h00, 1'b1);
        apb(0, `MPALU_OFF_STATUS, 32'h0);
        `MPALU_TB_CHK(rd[3], 1'b1)
        apb(1, `MPALU_OFF_STATUS, 32'h8);
        apb(0, `MPALU_OFF_STATUS, 32'h0);
        `MPALU_TB_CHK(rd[3], 1'b0)
        apb(0, `MPALU_OFF_HWERR, 32'h0);
        `MPALU_TB_CHK(rd, {23'h0, ~^8'h69, 8'h69})
        apb(0, `MPALU_OFF_DEVIN, 32'h0);
        `MPALU_TB_CHK(rd, {23'h0, ~^8'hcc, 8'hcc})
        apb(0, `MPALU_OFF_TAGREQ, 32'h0);
        `MPALU_TB_CHK(rd, 32'h6)
        apb(0, `MPALU_OFF_COUNTER, 32'h0);
        `MPALU_TB_CHK(rd, {5'h0, icExp + 11'h001, 5'h0, icExp})
        finalReport();
    end
endmodule // mpalu_tb_top
`default_nettype wire
